// >>> pdmc_pkg.sv
// constants and types of the pin drive mode control block
// Functional notes
// - each pin has its own three-bit drive-mode field choosing one of eight behaviours.
// - the driver value comes from the fabric when hardware output is enabled, else from the output latch.
// - the sampled pin level always updates pin state and reaches the fabric only when digital input is enabled.
// - codes 0 and 1 leave the pin high impedance; code 6 drives strongly high or low.
// - code 2 gives resistive high or strong low; code 3 gives strong high or resistive low.
// - code 4 drives strong low for 0 and releases the pin for 1.
// - code 5 drives strong high for 1 and releases the pin for 0.
// - code 7 gives weak resistive high for 1 and weak resistive low for 0.
// - every pin serves CPU and peripherals as digital input and output and can raise an interrupt.
// - drive modes load at power-on reset from a user-programmable per-port reset state.
package pdmc_pkg;
    localparam int NPINS = 8;
    localparam int AW = 4;
    localparam int DW = 8;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_OUT_LATCH = 4'h0;
    localparam logic [3:0] OFS_DSEL0 = 4'h1;
    localparam logic [3:0] OFS_DSEL1 = 4'h2;
    localparam logic [3:0] OFS_DSEL2 = 4'h3;
    localparam logic [3:0] OFS_PIN_STATE = 4'h4;
    localparam logic [3:0] OFS_HW_OUT_EN = 4'h5;
    localparam logic [3:0] OFS_HW_IN_EN = 4'h6;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h7;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
    localparam logic [3:0] OFS_IRQ_RISE = 4'h9;
    localparam logic [3:0] OFS_IRQ_FALL = 4'ha;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_EDGE_RISE = 8'hff;
    // ------------------------------------------------------------
    // drive behaviours
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DM_HIZ_ANALOG,
        DM_HIZ_DIGITAL,
        DM_RES_PULLUP,
        DM_RES_PULLDOWN,
        DM_OD_LOW,
        DM_OD_HIGH,
        DM_STRONG,
        DM_RES_BOTH
    } pdmc_mode_t;
endpackage

// >>> pdmc_top.sv
// pin drive mode control for one eight-pin port
`timescale 1ns/1ps
module pdmc_top
    import pdmc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [pdmc_pkg::AW-1:0] ADDR,
    input wire logic [pdmc_pkg::DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [pdmc_pkg::DW-1:0] RDATA,
    input wire logic [23:0] RESET_DRIVE_SEL,
    input wire logic [7:0] FABRIC_OUT,
    output logic [7:0] FABRIC_IN,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE,
    output logic [7:0] PULLUP_EN,
    output logic [7:0] PULLDOWN_EN,
    output logic [7:0] ANALOG_EN,
    output logic IRQ
);
    import pdmc_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_n;
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [7:0] port_output_latch;
    logic [7:0] drive_sel_bit0_reg;
    logic [7:0] drive_sel_bit1_reg;
    logic [7:0] drive_sel_bit2_reg;
    logic [7:0] hw_out_en_reg;
    logic [7:0] hw_in_en_reg;
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] irq_rise_reg;
    logic [7:0] irq_fall_reg;
    logic [7:0] pin_s1_reg;
    logic [7:0] pin_s2_reg;
    logic [7:0] pin_prev_reg;
    logic loaded_reg;
    logic [7:0] rdata_next;

    wire wr_latch = WR && (ADDR == OFS_OUT_LATCH);
    wire wr_dsel0 = WR && (ADDR == OFS_DSEL0);
    wire wr_dsel1 = WR && (ADDR == OFS_DSEL1);
    wire wr_dsel2 = WR && (ADDR == OFS_DSEL2);
    wire wr_hwo = WR && (ADDR == OFS_HW_OUT_EN);
    wire wr_hwi = WR && (ADDR == OFS_HW_IN_EN);
    wire wr_stat = WR && (ADDR == OFS_IRQ_STAT);
    wire wr_mask = WR && (ADDR == OFS_IRQ_MASK);
    wire wr_rise = WR && (ADDR == OFS_IRQ_RISE);
    wire wr_fall = WR && (ADDR == OFS_IRQ_FALL);

    // the strap is caught on the first cycle after reset release, since
    // an async reset may only load constants
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            loaded_reg <= 1'b0;
            drive_sel_bit0_reg <= RST_ZERO;
            drive_sel_bit1_reg <= RST_ZERO;
            drive_sel_bit2_reg <= RST_ZERO;
        end else begin
            loaded_reg <= 1'b1;
            for (int i = 0; i < NPINS; i++) begin
                if (!loaded_reg) begin
                    drive_sel_bit0_reg[i] <= RESET_DRIVE_SEL[3*i];
                    drive_sel_bit1_reg[i] <= RESET_DRIVE_SEL[3*i+1];
                    drive_sel_bit2_reg[i] <= RESET_DRIVE_SEL[3*i+2];
                end
            end
            if (loaded_reg && wr_dsel0) drive_sel_bit0_reg <= WDATA;
            if (loaded_reg && wr_dsel1) drive_sel_bit1_reg <= WDATA;
            if (loaded_reg && wr_dsel2) drive_sel_bit2_reg <= WDATA;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            port_output_latch <= RST_ZERO;
            hw_out_en_reg <= RST_ZERO;
            hw_in_en_reg <= RST_ZERO;
            irq_mask_reg <= RST_ZERO;
            irq_rise_reg <= RST_EDGE_RISE;
            irq_fall_reg <= RST_ZERO;
        end else begin
            if (wr_latch) port_output_latch <= WDATA;
            if (wr_hwo) hw_out_en_reg <= WDATA;
            if (wr_hwi) hw_in_en_reg <= WDATA;
            if (wr_mask) irq_mask_reg <= WDATA;
            if (wr_rise) irq_rise_reg <= WDATA;
            if (wr_fall) irq_fall_reg <= WDATA;
        end
    end

    // ------------------------------------------------------------
    // pin input path
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= RST_ZERO;
            pin_s2_reg <= RST_ZERO;
            pin_prev_reg <= RST_ZERO;
        end else begin
            pin_s1_reg <= PIN_IN;
            pin_s2_reg <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // input reaches the fabric only on pins whose input link is on
    assign FABRIC_IN = pin_s2_reg & hw_in_en_reg;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [7:0] rise_ev = pin_s2_reg & ~pin_prev_reg & irq_rise_reg;
    wire [7:0] fall_ev = ~pin_s2_reg & pin_prev_reg & irq_fall_reg;
    wire [7:0] pin_ev = rise_ev | fall_ev;
    wire [7:0] stat_clr = wr_stat ? WDATA : RST_ZERO;

    // set wins over a same-cycle clear
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= RST_ZERO;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~stat_clr) | pin_ev;
        end
    end

    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = RST_ZERO;
        if (ADDR == OFS_OUT_LATCH) rdata_next = port_output_latch;
        else if (ADDR == OFS_DSEL0) rdata_next = drive_sel_bit0_reg;
        else if (ADDR == OFS_DSEL1) rdata_next = drive_sel_bit1_reg;
        else if (ADDR == OFS_DSEL2) rdata_next = drive_sel_bit2_reg;
        else if (ADDR == OFS_PIN_STATE) rdata_next = pin_s2_reg;
        else if (ADDR == OFS_HW_OUT_EN) rdata_next = hw_out_en_reg;
        else if (ADDR == OFS_HW_IN_EN) rdata_next = hw_in_en_reg;
        else if (ADDR == OFS_IRQ_STAT) rdata_next = irq_stat_reg;
        else if (ADDR == OFS_IRQ_MASK) rdata_next = irq_mask_reg;
        else if (ADDR == OFS_IRQ_RISE) rdata_next = irq_rise_reg;
        else if (ADDR == OFS_IRQ_FALL) rdata_next = irq_fall_reg;
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= RST_ZERO;
        end else begin
            RDATA <= RD ? rdata_next : RST_ZERO;
        end
    end

    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    // fabric value is taken live; only the latch path is registered
    wire [7:0] out_val = (hw_out_en_reg & FABRIC_OUT) |
                         (~hw_out_en_reg & port_output_latch);

    // oe: strong drive, pull enables: weak resistor to the rail
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            PIN_OUT[i] = 1'b0;
            PIN_OE[i] = 1'b0;
            PULLUP_EN[i] = 1'b0;
            PULLDOWN_EN[i] = 1'b0;
            ANALOG_EN[i] = 1'b0;
            case (pdmc_mode_t'({drive_sel_bit2_reg[i], drive_sel_bit1_reg[i],
                               drive_sel_bit0_reg[i]}))
                DM_HIZ_ANALOG: begin
                    ANALOG_EN[i] = 1'b1;
                end
                DM_HIZ_DIGITAL: begin
                    PIN_OE[i] = 1'b0;
                end
                DM_RES_PULLUP: begin
                    PULLUP_EN[i] = out_val[i];
                    PIN_OE[i] = ~out_val[i];
                end
                DM_RES_PULLDOWN: begin
                    PULLDOWN_EN[i] = ~out_val[i];
                    PIN_OE[i] = out_val[i];
                    PIN_OUT[i] = 1'b1;
                end
                DM_OD_LOW: begin
                    PIN_OE[i] = ~out_val[i];
                end
                DM_OD_HIGH: begin
                    PIN_OE[i] = out_val[i];
                    PIN_OUT[i] = 1'b1;
                end
                DM_STRONG: begin
                    PIN_OE[i] = 1'b1;
                    PIN_OUT[i] = out_val[i];
                end
                default: begin
                    PULLUP_EN[i] = out_val[i];
                    PULLDOWN_EN[i] = ~out_val[i];
                end
            endcase
        end
    end
endmodule

// >>> pdmc_chk.sv
// concurrent checks on the ports of the pin drive mode control port
`timescale 1ns/1ps
module pdmc_chk
    import pdmc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [pdmc_pkg::AW-1:0] ADDR,
    input wire logic [pdmc_pkg::DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [pdmc_pkg::DW-1:0] RDATA,
    input wire logic [7:0] FABRIC_OUT,
    input wire logic [7:0] FABRIC_IN,
    input wire logic [7:0] PIN_IN,
    input wire logic [7:0] PIN_OUT,
    input wire logic [7:0] PIN_OE,
    input wire logic [7:0] PULLUP_EN,
    input wire logic [7:0] PULLDOWN_EN,
    input wire logic [7:0] ANALOG_EN,
    input wire logic IRQ
);
    // ----
    // shadow of the output and enable registers
    // ----
    logic [7:0] latch_reg, out_en_reg, in_en_reg;
    wire [7:0] drive_val = (out_en_reg & FABRIC_OUT) | (~out_en_reg & latch_reg);
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            latch_reg <= 8'h00;
            out_en_reg <= 8'h00;
            in_en_reg <= 8'h00;
        end else if (WR) begin
            if (ADDR == OFS_OUT_LATCH) latch_reg <= WDATA;
            if (ADDR == OFS_HW_OUT_EN) out_en_reg <= WDATA;
            if (ADDR == OFS_HW_IN_EN) in_en_reg <= WDATA;
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_mask_off;
        WR && ADDR == OFS_IRQ_MASK && WDATA == 8'h00;
    endsequence
    sequence s_irq_low;
        !IRQ [*3];
    endsequence
    AST_RDATA_IDLE: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (RD && ADDR > OFS_IRQ_FALL |=> !RDATA)
        else $error("unmapped read not zero");
    AST_DRIVE_VALUE: assert property ((PIN_OE & (PIN_OUT ^ drive_val)) == 0)
        else $error("driven pin level differs from output value");
    AST_PULL_VALUE: assert property ((PULLUP_EN & ~drive_val | PULLDOWN_EN & drive_val) == 0)
        else $error("pull direction differs from output value");
    AST_NO_FIGHT: assert property (((PULLUP_EN | PULLDOWN_EN) & PIN_OE) == 0)
        else $error("pull and strong driver together");
    AST_ANALOG_QUIET: assert property ((ANALOG_EN & (PIN_OE | PULLUP_EN | PULLDOWN_EN)) == 0)
        else $error("analog pin not released");
    AST_FABRIC_IN: assert property (FABRIC_IN == ($past(PIN_IN, 2) & in_en_reg))
        else $error("fabric input wrong");
    AST_MASK_OFF: assert property (s_mask_off |=> s_irq_low)
        else $error("interrupt high with all masked");
endmodule
bind pdmc_top pdmc_chk i_chk (.REF_CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .FABRIC_OUT, .FABRIC_IN, .PIN_IN, .PIN_OUT, .PIN_OE, .PULLUP_EN,
    .PULLDOWN_EN, .ANALOG_EN, .IRQ);

// >>> pdmc_board.sv
// board load model resolving the level seen at each pin
`timescale 1ns/1ps
module pdmc_board (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up,
    input wire logic [7:0] pull_dn,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_lvl
);
    // ----
    // pin resolution
    // ----
    logic [7:0] float_reg = 8'h00;
    // floating pins wander so a stale level never passes for a driven one
    always @(posedge clk) float_reg <= ~float_reg;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else if (pull_up[i]) pin_lvl[i] = 1'b1;
            else if (pull_dn[i]) pin_lvl[i] = 1'b0;
            else pin_lvl[i] = float_reg[i];
        end
    end
endmodule

// >>> test_pin_drive_mode_control.sv
// self-checking testbench of the pin drive mode control port
`timescale 1ns/1ps
module test_pin_drive_mode_control;
    import pdmc_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, irq;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, fab_out = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
    logic [7:0] rdata, fab_in, pin_in, pin_out, pin_oe, pu, pd, an;
    // pin i comes out of reset in mode i
    logic [23:0] rst_sel = 24'hfac688;
    int num_errors = 0, n_compared = 0;
    pdmc_top i_dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .ADDR(addr),
        .WDATA(wdata), .WR(bus_wr), .RD(bus_rd), .RDATA(rdata), .IRQ(irq),
        .RESET_DRIVE_SEL(rst_sel), .FABRIC_OUT(fab_out), .FABRIC_IN(fab_in),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_EN(pu),
        .PULLDOWN_EN(pd), .ANALOG_EN(an));
    pdmc_board i_board (.clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up(pu), .pull_dn(pd), .ext_val(ext_val), .ext_en(ext_en),
        .pin_lvl(pin_in));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // ----
    // bus and compare tasks
    // ----
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        @(negedge ref_clk);
        chk(nm, e, rdata);
    endtask
    // {oe, out, pullup, pulldown, analog} per mode and output value
    function automatic logic [4:0] drv(input logic [2:0] m, input logic v);
        case (m)
            3'h0: drv = 5'h01;
            3'h2: drv = v ? 5'h04 : 5'h10;
            3'h3: drv = v ? 5'h18 : 5'h02;
            3'h4: drv = v ? 5'h00 : 5'h10;
            3'h5: drv = v ? 5'h18 : 5'h00;
            3'h6: drv = {1'b1, v, 3'h0};
            3'h7: drv = v ? 5'h04 : 5'h02;
            default: drv = 5'h00;
        endcase
    endfunction
    task automatic t_modes();
        logic [7:0] oe, ov, u, d, a;
        rd(OFS_DSEL0, 8'haa, "dsel0");
        rd(OFS_DSEL1, 8'hcc, "dsel1");
        rd(OFS_DSEL2, 8'hf0, "dsel2");
        for (int v = 0; v < 2; v++) begin
            wr(OFS_OUT_LATCH, v ? 8'hff : 8'h00);
            @(negedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                {oe[i], ov[i], u[i], d[i], a[i]} = drv(i[2:0], v[0]);
            end
            chk("oe", oe, pin_oe);
            chk("out", ov & oe, pin_out & pin_oe);
            chk("pullup", u, pu);
            chk("pulldown", d, pd);
            chk("analog", a, an);
        end
    endtask
    task automatic t_bypass();
        @(posedge ref_clk);
        fab_out <= 8'h55;
        wr(OFS_DSEL0, 8'h00);
        wr(OFS_DSEL1, 8'hff);
        wr(OFS_DSEL2, 8'hff);
        wr(OFS_OUT_LATCH, 8'h0f);
        wr(OFS_HW_OUT_EN, 8'hf0);
        @(negedge ref_clk);
        chk("oe", 8'hff, pin_oe);
        chk("out", 8'h5f, pin_out);
        @(posedge ref_clk);
        fab_out <= 8'haa;
        repeat (3) @(posedge ref_clk);
        rd(OFS_PIN_STATE, 8'haf, "state");
        wr(OFS_HW_IN_EN, 8'h3c);
        @(negedge ref_clk);
        chk("fabric_in", 8'h2c, fab_in);
        wr(OFS_PIN_STATE, 8'h00);
        rd(OFS_PIN_STATE, 8'haf, "state");
        rd(4'hf, 8'h00, "unmapped");
    endtask
    task automatic t_irq();
        @(posedge ref_clk);
        ext_en <= 8'hff;
        wr(OFS_HW_OUT_EN, 8'h00);
        wr(OFS_DSEL0, 8'hff);
        wr(OFS_DSEL1, 8'h00);
        wr(OFS_DSEL2, 8'h00);
        repeat (4) @(posedge ref_clk);
        wr(OFS_IRQ_STAT, 8'hff);
        wr(OFS_IRQ_MASK, 8'h03);
        rd(OFS_IRQ_STAT, 8'h00, "status");
        @(posedge ref_clk);
        ext_val <= 8'h11;
        repeat (5) @(negedge ref_clk);
        chk("irq", 8'h01, {7'h0, irq});
        rd(OFS_IRQ_STAT, 8'h11, "status");
        wr(OFS_IRQ_MASK, 8'h02);
        @(negedge ref_clk);
        chk("irq", 8'h00, {7'h0, irq});
        wr(OFS_IRQ_RISE, 8'h00);
        wr(OFS_IRQ_FALL, 8'h02);
        ext_val <= 8'h13;
        repeat (5) @(posedge ref_clk);
        ext_val <= 8'h11;
        repeat (5) @(negedge ref_clk);
        chk("irq", 8'h01, {7'h0, irq});
        wr(OFS_IRQ_STAT, 8'h02);
        @(negedge ref_clk);
        chk("irq", 8'h00, {7'h0, irq});
        rd(OFS_IRQ_STAT, 8'h11, "status");
        wr(OFS_IRQ_MASK, 8'h13);
        @(negedge ref_clk);
        chk("irq", 8'h01, {7'h0, irq});
        wr(OFS_IRQ_MASK, 8'h00);
        @(negedge ref_clk);
        chk("irq", 8'h00, {7'h0, irq});
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(4000 * 40);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_modes();
        t_bypass();
        t_irq();
        wrap_up();
    end
endmodule
